// *** bss_motor_model.sv ***
// Purpose: behavioural motor, power stage and holding brake
// Assumes: speed in mm/s, one speed step per core clock
// Notes:   hold freezes a free-running motor so timeout paths are reached
`default_nettype none

module bss_motor_model (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        motor_power_on,
  input  wire logic        dynamic_braking,
  input  wire logic        zero_speed_stop,
  input  wire logic        brake_release_output_n,
  input  wire logic [13:0] target,
  input  wire logic        hold,
  output logic      [13:0] motor_speed
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        braking;
  logic [13:0] step;

  // brake pin has its own input here, shared with nothing else
  assign braking = dynamic_braking || zero_speed_stop || brake_release_output_n;
  // coasting sheds speed slowly, any braking quickly
  assign step    = braking ? 14'h0019 : 14'h0005;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      motor_speed <= 14'h0000;
    end else if (motor_power_on && !zero_speed_stop && !brake_release_output_n) begin
      motor_speed <= target;
    end else if (!hold) begin
      motor_speed <= (motor_speed > step) ? motor_speed - step : 14'h0000;
    end
  end
endmodule : bss_motor_model

`default_nettype wire

// *** bss_pkg.sv ***
// Purpose: constants and types of the brake and stop sequencer
// Assumes: 100 MHz core clock; speeds in mm/s; times in 10 ms units
// Notes:   register offsets are byte addresses on the plain register port
//
// Operation
// (RL1) an alarm while moving stops the motor and applies the brake
// (RL2) brake speed threshold 0..10000 mm/s, default 10, effective at once
// (RL3) brake wait timeout 10..100 x 10 ms, default 50, effective at once
// (RL4) after power removal while moving, brake when speed drops below threshold
// (RL5) after power removal while moving, brake once the wait timeout elapses
// (RL6) brake pin high means the brake is applied
// (RL7) threshold above motor maximum speed is limited to the maximum speed
// (RL8) zero-speed alarm stop follows standstill brake timing after stopping
// (RL9) integrator keeps brake pin on its own terminal, never shared
// (RL10) main power loss without servo-off stops by dynamic braking
// (RL11) control power loss stop is fixed by variant: coast or dynamic braking
// (RL12) stop method 0 db/db, 1 db/coast, 2 coast/coast, after restart
// (RL13) dynamic brake hold gives no force at standstill or very low speed
// (RL14) group one alarms use stop method, group two its own field
// (RL15) group one alarm stops exactly like a servo-off command; here only while moving, at standstill power is cut at once
// (RL16) group two field 0 zero-speed then post mode, 1 full stop method
// (RL17) group two field used in position and speed control, ignored in force
// (RL18) brake pin on releases the brake, off applies it
// (RL19) standstill servo-off brakes at once, power off after 0..50 x 10 ms
// (RL20) both moving conditions race; first one applies brake, then it holds
`default_nettype none

package bss_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_MS  = 10;
  localparam int TICK_CYCLES   = TICK_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int PRE_W         = 20;
  localparam int ELAPSED_W     = 7;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 5;
  localparam logic [4:0]  OFS_STOP    = 5'h00;
  localparam logic [4:0]  OFS_THR     = 5'h04;
  localparam logic [4:0]  OFS_TMO     = 5'h08;
  localparam logic [4:0]  OFS_DLY     = 5'h0C;
  localparam logic [4:0]  OFS_MAXSPD  = 5'h10;
  localparam logic [4:0]  OFS_STATUS  = 5'h14;
  localparam int          SEL_LSB     = 0;
  localparam int          G2_BIT      = 4;
  localparam int          MODE_LSB    = 8;
  localparam int          APPLY_BIT   = 31;

  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [13:0] THR_RST     = 14'h000A;
  localparam logic [31:0] THR_MAX     = 32'h0000_2710;
  localparam logic [6:0]  TMO_RST     = 7'h32;
  localparam logic [31:0] TMO_MIN     = 32'h0000_000A;
  localparam logic [31:0] TMO_MAX     = 32'h0000_0064;
  localparam logic [5:0]  DLY_RST     = 6'h00;
  localparam logic [31:0] DLY_MAX     = 32'h0000_0032;
  localparam logic [13:0] MAXSPD_RST  = 14'h1388;
  localparam logic [13:0] MOTION_LVL  = 14'h0014;

  typedef enum logic [1:0] {
    SM_DB_DB    = 2'b00,
    SM_DB_COAST = 2'b01,
    SM_COAST    = 2'b10
  } bss_method_t;

  typedef enum logic [1:0] {
    CM_POS   = 2'b00,
    CM_SPEED = 2'b01,
    CM_FORCE = 2'b10
  } bss_mode_t;

  typedef enum logic [2:0] {
    ST_RUN      = 3'b000,
    ST_HOLD_DLY = 3'b001,
    ST_ZSTOP    = 3'b010,
    ST_MOVE_WT  = 3'b011,
    ST_STOPPED  = 3'b100
  } bss_state_t;

endpackage : bss_pkg

`default_nettype wire

// *** bss_sequencer.sv ***
// Purpose: stop method selection and holding brake timing of a servo drive
// Assumes: motor_speed is a same-clock magnitude in mm/s; pins are async
// Notes:   brake_release_output_n high means brake applied
`default_nettype none

module bss_sequencer #(
  parameter int TICK_CYCLES       = bss_pkg::TICK_CYCLES,
  parameter bit CTRL_LOSS_COASTS  = 1'b0
) (
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  input  wire logic [bss_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic [31:0]                     reg_rdata,
  input  wire logic                       servo_on_command,
  input  wire logic                       group_one_alarm,
  input  wire logic                       group_two_alarm,
  input  wire logic                       main_power_lost,
  input  wire logic                       control_power_lost,
  input  wire logic [13:0]                motor_speed,
  output logic                            motor_power_on,
  output logic                            dynamic_braking,
  output logic                            zero_speed_stop,
  output logic                            brake_release_output_n
);
  import bss_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pin_raw;
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic       srv_prev_q;

  assign pin_raw = {control_power_lost, main_power_lost, group_two_alarm,
                    group_one_alarm, servo_on_command};

  for (genvar i = 0; i < 5; i++) begin : g_sync
    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        sync1_q[i] <= 1'b0;
        sync2_q[i] <= 1'b0;
      end else begin
        sync1_q[i] <= pin_raw[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) srv_prev_q <= 1'b0;
    else       srv_prev_q <= sync2_q[0];
  end

  wire srv_on    = sync2_q[0];
  wire srv_rise  = srv_on & ~srv_prev_q;
  wire alm1      = sync2_q[1];
  wire alm2      = sync2_q[2];
  wire main_lost = sync2_q[3];
  wire ctrl_lost = sync2_q[4];
  wire fault     = alm1 | alm2 | main_lost | ctrl_lost;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  bss_method_t pend_sel_q, act_sel_q;
  logic        pend_g2_q, act_g2_q;
  bss_mode_t   mode_q;
  logic [13:0] thr_q;
  logic [6:0]  tmo_q;
  logic [5:0]  dly_q;
  logic [13:0] max_spd_q;
  logic [31:0] reg_rdata_q;

  wire wr_stop = reg_wr && (reg_addr == OFS_STOP);
  wire wr_thr  = reg_wr && (reg_addr == OFS_THR);
  wire wr_tmo  = reg_wr && (reg_addr == OFS_TMO);
  wire wr_dly  = reg_wr && (reg_addr == OFS_DLY);
  wire wr_max  = reg_wr && (reg_addr == OFS_MAXSPD);

  // out-of-range writes saturate so the timing never leaves its span
  wire [13:0] thr_w = (reg_wdata > THR_MAX) ? THR_MAX[13:0] : reg_wdata[13:0]; // RL2
  wire [6:0]  tmo_w = (reg_wdata < TMO_MIN) ? TMO_MIN[6:0] :
                      (reg_wdata > TMO_MAX) ? TMO_MAX[6:0] : reg_wdata[6:0]; // RL3
  wire [5:0]  dly_w = (reg_wdata > DLY_MAX) ? DLY_MAX[5:0] : reg_wdata[5:0]; // RL19
  wire [1:0]  sel_w = reg_wdata[SEL_LSB+1:SEL_LSB];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pend_sel_q <= SM_DB_DB;
      pend_g2_q  <= 1'b0;
      mode_q     <= CM_POS;
      thr_q      <= THR_RST;
      tmo_q      <= TMO_RST;
      dly_q      <= DLY_RST;
      max_spd_q  <= MAXSPD_RST;
    end else begin
      if (wr_stop) begin
        // illegal code 3 falls back to the default method
        pend_sel_q <= (sel_w == 2'b11) ? SM_DB_DB : bss_method_t'(sel_w);
        pend_g2_q  <= reg_wdata[G2_BIT];
        mode_q     <= bss_mode_t'(reg_wdata[MODE_LSB+1:MODE_LSB]);
      end
      if (wr_thr) thr_q <= thr_w; // RL2
      if (wr_tmo) tmo_q <= tmo_w; // RL3
      if (wr_dly) dly_q <= dly_w;
      if (wr_max) max_spd_q <= reg_wdata[13:0];
    end
  end

  // stop fields only change on a restart request
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      act_sel_q <= SM_DB_DB;
      act_g2_q  <= 1'b0;
    end else if (wr_stop && reg_wdata[APPLY_BIT]) begin
      act_sel_q <= (sel_w == 2'b11) ? SM_DB_DB : bss_method_t'(sel_w); // RL12
      act_g2_q  <= reg_wdata[G2_BIT]; // RL16
    end
  end

  // ----------------------------------------------------------------
  // stop decision
  // ----------------------------------------------------------------
  bss_state_t  st_q, st_d;
  logic        brake_q, brake_d, pwr_q, pwr_d, db_q, db_d, zs_q, zs_d;
  logic        stop_db_q, stop_db_d, post_db_q, post_db_d;
  logic [6:0]  elapsed;

  wire [13:0] eff_thr = (thr_q > max_spd_q) ? max_spd_q : thr_q; // RL7
  wire        moving  = (motor_speed >= MOTION_LVL);
  wire        g2_own  = (mode_q != CM_FORCE) && !act_g2_q; // RL17
  wire        m_db    = (act_sel_q != SM_COAST); // RL12
  wire        m_post  = (act_sel_q == SM_DB_DB);
  // priority: control loss, main loss, group one, group two, servo-off
  wire        c_zero  = !ctrl_lost && !main_lost && !alm1 && alm2 && g2_own; // RL16
  wire        c_db    = ctrl_lost ? !CTRL_LOSS_COASTS : // RL11
                        main_lost ? 1'b1 : m_db; // RL10 RL15
  wire        c_post  = ctrl_lost ? !CTRL_LOSS_COASTS :
                        main_lost ? 1'b1 : m_post; // RL14
  wire        stop_now = (st_q == ST_RUN) && (fault || !srv_on);
  wire        brk_mv   = (motor_speed < eff_thr); // RL4
  wire        brk_tmo  = (elapsed >= tmo_q); // RL5
  wire        dly_done = (elapsed >= {1'b0, dly_q});

  always_comb begin
    st_d      = st_q;
    brake_d   = brake_q;
    pwr_d     = pwr_q;
    zs_d      = 1'b0;
    stop_db_d = stop_db_q;
    post_db_d = post_db_q;
    unique case (st_q)
      ST_RUN: begin
        if (stop_now) begin
          stop_db_d = c_db;
          post_db_d = c_post;
          if (!fault && !moving) begin
            st_d    = ST_HOLD_DLY; // RL19
            brake_d = 1'b1;
          end else if (c_zero && moving) begin
            st_d = ST_ZSTOP;
            zs_d = 1'b1;
          end else if (!moving) begin
            st_d    = ST_STOPPED;
            brake_d = 1'b1;
            pwr_d   = 1'b0;
          end else begin
            st_d  = ST_MOVE_WT; // RL1
            pwr_d = 1'b0;
          end
        end
      end
      ST_HOLD_DLY: begin
        // a fresh alarm cuts power at once; a zero-speed alarm keeps the delay
        if (dly_done || ctrl_lost || main_lost || alm1 || (alm2 && !g2_own)) begin // RL8
          st_d  = ST_STOPPED;
          pwr_d = 1'b0;
        end
      end
      ST_ZSTOP: begin
        if (main_lost || ctrl_lost) begin
          st_d      = ST_MOVE_WT;
          pwr_d     = 1'b0;
          stop_db_d = c_db;
        end else if (!moving) begin
          st_d    = ST_HOLD_DLY; // RL8
          brake_d = 1'b1;
        end else begin
          zs_d = 1'b1;
        end
      end
      ST_MOVE_WT: begin
        if (brk_mv || brk_tmo) begin
          st_d    = ST_STOPPED; // RL20
          brake_d = 1'b1;
        end
      end
      ST_STOPPED: begin
        if (srv_rise && !fault) begin
          st_d    = ST_RUN;
          brake_d = 1'b0; // RL18
          pwr_d   = 1'b1;
        end
      end
      default: begin
        st_d    = ST_STOPPED;
        brake_d = 1'b1;
        pwr_d   = 1'b0;
      end
    endcase
    // hold braking vanishes at very low speed, like coasting
    db_d = (st_d == ST_MOVE_WT) ? stop_db_d :
           (st_d == ST_STOPPED || st_d == ST_HOLD_DLY) ? (post_db_d & moving) // RL13
           : 1'b0;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q      <= ST_STOPPED;
      brake_q   <= 1'b1;
      pwr_q     <= 1'b0;
      db_q      <= 1'b0;
      zs_q      <= 1'b0;
      stop_db_q <= 1'b0;
      post_db_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      brake_q   <= brake_d;
      pwr_q     <= pwr_d;
      db_q      <= db_d;
      zs_q      <= zs_d;
      stop_db_q <= stop_db_d;
      post_db_q <= post_db_d;
    end
  end

  bss_unit_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clear    (st_d != st_q),
    .elapsed  (elapsed)
  );

  // ----------------------------------------------------------------
  // read port and outputs
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  assign rd_mux =
    (reg_addr == OFS_STOP)   ? {27'h0, pend_g2_q, 2'h0, pend_sel_q} |
                               {22'h0, mode_q, 8'h0} :
    (reg_addr == OFS_THR)    ? {18'h0, thr_q} :
    (reg_addr == OFS_TMO)    ? {25'h0, tmo_q} :
    (reg_addr == OFS_DLY)    ? {26'h0, dly_q} :
    (reg_addr == OFS_MAXSPD) ? {18'h0, max_spd_q} :
    (reg_addr == OFS_STATUS) ? {22'h0, act_g2_q, act_sel_q, zs_q, db_q, pwr_q,
                                brake_q, st_q} : 32'h0;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) reg_rdata_q <= 32'h0;
    else       reg_rdata_q <= reg_rd ? rd_mux : 32'h0;
  end

  assign reg_rdata              = reg_rdata_q;
  assign motor_power_on         = pwr_q;
  assign dynamic_braking        = db_q;
  assign zero_speed_stop        = zs_q;
  assign brake_release_output_n = brake_q; // RL6 RL18

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_off_still;
    (st_q == ST_RUN) && !srv_on && !fault && !moving;
  endsequence

  sequence s_zs_done;
    (st_q == ST_ZSTOP) && !moving && !main_lost && !ctrl_lost;
  endsequence

  alarm_stop_a: assert property ( // RL1
    (st_q == ST_RUN) && alm1 |=> !pwr_q && (st_q != ST_RUN)
  ) else $error("alarm did not stop the motor");
  thr_clamp_a: assert property ( // RL2
    wr_thr && (reg_wdata > THR_MAX) |=> thr_q == THR_MAX[13:0]
  ) else $error("threshold not clamped");
  tmo_range_a: assert property ( // RL3
    (tmo_q >= TMO_MIN[6:0]) && (tmo_q <= TMO_MAX[6:0])
  ) else $error("timeout out of range");
  brake_speed_a: assert property ( // RL4
    (st_q == ST_MOVE_WT) && brk_mv |=> brake_release_output_n && !pwr_q
  ) else $error("brake late on low speed");
  brake_tmo_a: assert property ( // RL5
    (st_q == ST_MOVE_WT) && brk_tmo |=> brake_release_output_n
  ) else $error("brake late on timeout");
  max_limit_a: assert property ( // RL7
    (eff_thr <= max_spd_q) && (eff_thr <= thr_q)
  ) else $error("threshold above maximum speed");
  zs_hold_a: assert property ( // RL8
    s_zs_done |=> (st_q == ST_HOLD_DLY) && brake_q && pwr_q
  ) else $error("zero speed stop skipped standstill timing");
  main_db_a: assert property ( // RL10
    (st_q == ST_RUN) && main_lost && !ctrl_lost && moving |=> db_q ##0 !pwr_q
  ) else $error("main loss not dynamic braked");
  ctrl_loss_a: assert property ( // RL11
    (st_q == ST_RUN) && ctrl_lost && moving |=> db_q == !CTRL_LOSS_COASTS
  ) else $error("control loss stop wrong for variant");
  restart_a: assert property ( // RL12
    wr_stop && !reg_wdata[APPLY_BIT] |=> $stable(act_sel_q) && $stable(act_g2_q)
  ) else $error("stop method changed without restart");
  db_low_a: assert property ( // RL13
    (st_q == ST_STOPPED) && !moving && !srv_rise |=> !db_q
  ) else $error("braking force at standstill");
  g2_zero_a: assert property ( // RL16
    (st_q == ST_RUN) && alm2 && !alm1 && !main_lost && !ctrl_lost && moving
      && g2_own |=> (st_q == ST_ZSTOP) && zs_q && pwr_q
  ) else $error("group two alarm did not zero speed stop");
  force_g2_a: assert property ( // RL17
    (st_q == ST_RUN) && alm2 && (mode_q == CM_FORCE) |=> st_q != ST_ZSTOP
  ) else $error("group two field used in force control");
  still_off_a: assert property ( // RL19
    s_off_still |=> brake_q && pwr_q ##1 (pwr_q || dly_q == 6'h00 || $past(fault))
  ) else $error("standstill servo off timing wrong");
  brake_hold_a: assert property ( // RL20
    (st_q == ST_STOPPED) && !srv_rise |=> brake_q
  ) else $error("brake released while stopped");

endmodule : bss_sequencer

`default_nettype wire

// *** bss_unit_timer.sv ***
// Purpose: elapsed time in 10 ms units since the last clear
// Assumes: clear is a same-clock pulse
// Notes:   saturates so a long wait never wraps back below a limit
`default_nettype none

module bss_unit_timer #(
  parameter int TICK_CYCLES = bss_pkg::TICK_CYCLES
) (
  input  wire logic                         core_clk,
  input  wire logic                         rstn,
  input  wire logic                         clear,
  output logic [bss_pkg::ELAPSED_W-1:0]     elapsed
);
  import bss_pkg::*;

  logic [PRE_W-1:0]     pre_q;
  logic [ELAPSED_W-1:0] cnt_q;
  wire                  tick = (pre_q == PRE_W'(TICK_CYCLES - 1));
  wire                  sat  = &cnt_q;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= '0;
      cnt_q <= '0;
    end else if (clear) begin
      pre_q <= '0;
      cnt_q <= '0;
    end else begin
      pre_q <= tick ? '0 : pre_q + 1'b1;
      cnt_q <= (tick && !sat) ? cnt_q + 1'b1 : cnt_q;
    end
  end

  assign elapsed = cnt_q;

endmodule : bss_unit_timer

`default_nettype wire

// *** tb_bss_sequencer.sv ***
// Purpose: self-checking bench of the brake and stop sequencer
// Assumes: short tick, so every timing limit is a few hundred cycles at most
// Notes:   pins pass two sync flops, checks leave a few cycles of slack
`default_nettype none

module tb_bss_sequencer
  import bss_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  localparam int TICK = 4;
  localparam int NR   = 10;

  logic              core_clk, rstn, reg_wr, reg_rd, hold;
  logic [ADDR_W-1:0] reg_addr;
  logic [31:0]       reg_wdata, reg_rdata;
  logic              son, g1, g2, mloss, closs;
  logic [13:0]       motor_speed, target;
  logic              power, db, zero, brake;
  int                errors, n_tests;
  // digits: method, g2 select, mode, event, db, zero stop, power
  logic [27:0]       row[NR] = '{
    28'h1001100,
    28'h2000000,
    28'h2003100,
    28'h2004100,
    28'h0102100,
    28'h0022100,
    28'h0002011,
    28'h0000100,
    28'h1000100,
    28'h0012011
  };

  bss_sequencer #(.TICK_CYCLES(TICK), .CTRL_LOSS_COASTS(1'b0)) bss_sequencer_i (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .servo_on_command(son),
    .group_one_alarm(g1), .group_two_alarm(g2), .main_power_lost(mloss),
    .control_power_lost(closs), .motor_speed(motor_speed), .motor_power_on(power),
    .dynamic_braking(db), .zero_speed_stop(zero), .brake_release_output_n(brake));

  bss_motor_model bss_motor_model_i (
    .core_clk(core_clk), .rstn(rstn), .motor_power_on(power), .dynamic_braking(db),
    .zero_speed_stop(zero), .brake_release_output_n(brake), .target(target),
    .hold(hold), .motor_speed(motor_speed));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    @(negedge core_clk);
    check(reg_rdata, exp);
  endtask : rd

  function automatic logic pick(input int w);
    case (w)
      0:       pick = brake;
      1:       pick = power;
      default: pick = db;
    endcase
  endfunction : pick

  task automatic wait_for(input int w, input logic v, input int max);
    for (int i = 0; i < max && pick(w) !== v; i++) @(negedge core_clk);
    check(pick(w), v);
  endtask : wait_for

  // apply bit doubles as the restart that loads the stop fields
  task automatic start(input logic [1:0] m, input logic s, input logic [1:0] md,
                       input logic [13:0] t);
    wr(OFS_STOP, {1'b1, 21'h0, md, 3'h0, s, 2'h0, m});
    @(posedge core_clk);
    target <= t;
    son    <= 1'b1;
    wait_for(1, 1'b1, 10);
    check(brake, 1'b0);
    repeat (4) @(negedge core_clk);
  endtask : start

  task automatic raise(input int ev);
    @(posedge core_clk);
    case (ev)
      0:       son   <= 1'b0;
      1:       g1    <= 1'b1;
      2:       g2    <= 1'b1;
      3:       mloss <= 1'b1;
      default: closs <= 1'b1;
    endcase
    repeat (5) @(negedge core_clk);
  endtask : raise

  task automatic idle();
    @(posedge core_clk);
    {son, g1, g2, mloss, closs, hold} <= 6'h00;
    wait_for(0, 1'b1, 300);
    wait_for(1, 1'b0, 300);
    repeat (60) @(negedge core_clk);
  endtask : idle

  // ----------------------------------------------------------------
  // clock, watchdog and test sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    errors++;
    end_sim();
  end

  initial begin
    rstn      = 1'b0;
    {reg_wr, reg_rd, son, g1, g2, mloss, closs, hold} = 8'h00;
    reg_addr  = '0;
    reg_wdata = '0;
    target    = '0;
    errors    = 0;
    n_tests   = 0;
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    check(brake, 1'b1);
    rd(OFS_STOP, 32'h0);
    rd(OFS_THR, 32'h0000_000A);
    rd(OFS_TMO, 32'h0000_0032);
    rd(OFS_DLY, 32'h0);
    rd(OFS_MAXSPD, 32'h0000_1388);
    rd(OFS_STATUS, 32'h0000_000C);
    wr(OFS_THR, 32'h0000_4E20);
    rd(OFS_THR, THR_MAX);
    wr(OFS_TMO, 32'h0000_0005);
    rd(OFS_TMO, TMO_MIN);
    wr(OFS_TMO, 32'h0000_00C8);
    rd(OFS_TMO, TMO_MAX);
    wr(OFS_DLY, 32'h0000_003C);
    rd(OFS_DLY, DLY_MAX);
    wr(OFS_STOP, 32'h0000_0003);
    rd(OFS_STOP, 32'h0);
    wr(5'h18, 32'hFFFF_FFFF);
    rd(5'h18, 32'h0);
    wr(OFS_STOP, 32'h0000_0211);
    rd(OFS_STOP, 32'h0000_0211);
    rd(OFS_STATUS, 32'h0000_000C);
    wr(OFS_THR, 32'h0000_000A);
    wr(OFS_TMO, 32'h0000_0032);
    wr(OFS_DLY, 32'h0000_0003);
    // ------------------------------------------------------------
    // stop methods per command, alarm group and power loss
    // ------------------------------------------------------------
    for (int r = 0; r < NR; r++) begin
      start(row[r][25:24], row[r][20], row[r][17:16], 14'h03E8);
      raise(int'(row[r][14:12]));
      check(db, row[r][8]);
      check(zero, row[r][4]);
      check(power, row[r][0]);
      wait_for(0, 1'b1, 300);
      if (row[r][4]) begin
        check(power, 1'b1);
        repeat (4) @(negedge core_clk);
        check(power, 1'b1);
        wait_for(1, 1'b0, 40);
      end
      repeat (2) @(negedge core_clk);
      check(db, 1'b0);
      idle();
    end
    // speed threshold crossing while moving
    wr(OFS_THR, 32'h0000_01F4);
    start(2'h0, 1'b0, 2'h0, 14'h03E8);
    raise(0);
    wait_for(0, 1'b1, 60);
    check(motor_speed < 14'h01F4, 1'b1);
    check(motor_speed > 14'h0190, 1'b1);
    idle();
    // threshold above max speed: only the timeout may apply the brake
    wr(OFS_THR, 32'h0000_2710);
    wr(OFS_MAXSPD, 32'h0000_012C);
    wr(OFS_TMO, 32'h0000_000A);
    start(2'h0, 1'b0, 2'h0, 14'h03E8);
    @(posedge core_clk);
    hold <= 1'b1;
    raise(0);
    repeat (30) @(negedge core_clk);
    check(brake, 1'b0);
    wait_for(0, 1'b1, 20);
    repeat (8) @(negedge core_clk);
    check(brake, 1'b1);
    check(db, 1'b1);
    idle();
    wr(OFS_MAXSPD, 32'h0000_1388);
    // servo-off at standstill: brake first, power off after delay
    start(2'h0, 1'b0, 2'h0, 14'h0000);
    raise(0);
    check(brake, 1'b1);
    check(power, 1'b1);
    rd(OFS_STATUS, 32'h0000_0019);
    repeat (4) @(negedge core_clk);
    check(power, 1'b1);
    wait_for(1, 1'b0, 20);
    idle();
    end_sim();
  end
endmodule : tb_bss_sequencer

`default_nettype wire
